/* src/usr_core.v */
/*
 * Eight-bit storage core of the universal shift register: hold, shift right,
 * shift left and parallel load, plus a clear that overrides every mode.
 * Assumes step, mode and serial inputs are synchronous to aclk; ce freezes it.
 */
`timescale 1ns/1ps
`include "usr_regs.vh"

module usr_core (
    input wire aclk,            // System clock.
    input wire aresetn,         // Synchronous reset, active low.
    input wire ce,              // Clock enable, freezes state while low.
    input wire clear,           // Clear request, wins over any step.
    input wire step,            // One operation in the selected mode.
    input wire [1:0] mode,      // {high select, low select}.
    input wire sin_right,       // Serial bit entering bit 0 on right shifts.
    input wire sin_left,        // Serial bit entering bit 7 on left shifts.
    input wire [7:0] load_data, // Parallel load value.
    output reg [7:0] data_q     // Stored value.
);

    reg [7:0] data_d;

    ////////////////////////////////////////////////////////////////////////////

    always @* begin
        data_d = data_q;
        if (clear) begin
            data_d = `USR_DATA_RST;
        end else if (step) begin
            case (mode)
                `USR_MODE_HOLD: data_d = data_q;
                `USR_MODE_RIGHT: data_d = {data_q[6:0], sin_right};
                `USR_MODE_LEFT: data_d = {sin_left, data_q[7:1]};
                `USR_MODE_LOAD: data_d = load_data;
                default: data_d = data_q;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            data_q <= `USR_DATA_RST;
        end else if (ce) begin
            data_q <= data_d;
        end
    end

endmodule

/* src/usr_regs.vh */
/*
 * Constants shared by the universal shift register block: register offsets,
 * field positions, reset values and mode encodings.
 * Assumes it is included by its bare name from the design files under src/.
 */
`ifndef USR_REGS_VH
`define USR_REGS_VH

// Register byte offsets on the AXI4-Lite slave.
`define USR_CTRL_OFS 8'h00
`define USR_CMD_OFS 8'h04
`define USR_LOAD_OFS 8'h08
`define USR_STAT_OFS 8'h0c
`define USR_COUNT_OFS 8'h10

// Control register fields.
`define USR_CTRL_OWN 0
`define USR_CTRL_MODE_LO 1
`define USR_CTRL_MODE_HI 2
`define USR_CTRL_SIN_R 3
`define USR_CTRL_SIN_L 4
`define USR_CTRL_RST 32'h0000_0000

// Command register fields, write-only pulses.
`define USR_CMD_STEP 0
`define USR_CMD_CLEAR 1

// Status register fields.
`define USR_STAT_DRIVE 8
`define USR_STAT_MODE_LO 9
`define USR_STAT_MODE_HI 10

// Mode encodings as {mode_select_high, mode_select_low}.
`define USR_MODE_HOLD 2'b00
`define USR_MODE_RIGHT 2'b01
`define USR_MODE_LEFT 2'b10
`define USR_MODE_LOAD 2'b11

// AXI response codes.
`define USR_RESP_OKAY 2'b00
`define USR_RESP_SLVERR 2'b10

`define USR_DATA_RST 8'h00
`define USR_COUNT_RST 16'h0000

`endif

/* src/usr_top.v */
/*
 * Top of the universal shift register block: the pin-level shift register
 * with its three-state parallel bus and serial taps, plus an AXI4-Lite slave
 * through which software can watch the register and optionally drive it.
 * Assumes all pins are synchronous to aclk and that the bus partner drives
 * the parallel bus only while parallel_bus_oe_n is high.
 * A shift_clock rise made while ce is low counts if the pin stays high.
 * Only byte lane 0 of a write matters; awprot and arprot are unused.
 */
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "usr_regs.vh"


module usr_top (
    input wire aclk,                  // System clock, 50 MHz.
    input wire aresetn,               // Synchronous reset, active low.
    input wire ce,                    // Clock enable, freezes all state when low.
    // Shift register pins.
    input wire shift_clock,           // Shift clock pin, rising edge acts.
    input wire master_clear_n,        // Master clear pin, active low.
    input wire mode_select_low,       // Mode select, low bit.
    input wire mode_select_high,      // Mode select, high bit.
    input wire serial_in_right,       // Serial input for right shifts.
    input wire serial_in_left,        // Serial input for left shifts.
    input wire out_enable_a_n,        // Parallel output enable, active low.
    input wire out_enable_b_n,        // Parallel output enable, active low.
    input wire [7:0] parallel_bus_i,  // Parallel bus, level seen on the pins.
    output wire [7:0] parallel_bus_o, // Parallel bus, value driven.
    output reg parallel_bus_oe_n,     // Parallel bus enable, low drives.
    output wire serial_tap_first,     // Lowest register bit.
    output wire serial_tap_last,      // Highest register bit.
    // AXI4-Lite register slave.
    input wire [7:0] s_axi_awaddr,    // AXI write address.
    input wire [2:0] s_axi_awprot,    // AXI write protection, unused.
    input wire s_axi_awvalid,         // AXI write address valid.
    output reg s_axi_awready,         // AXI write address ready.
    input wire [31:0] s_axi_wdata,    // AXI write data.
    input wire [3:0] s_axi_wstrb,     // AXI write byte strobes.
    input wire s_axi_wvalid,          // AXI write data valid.
    output reg s_axi_wready,          // AXI write data ready.
    output reg [1:0] s_axi_bresp,     // AXI write response.
    output reg s_axi_bvalid,          // AXI write response valid.
    input wire s_axi_bready,          // AXI write response ready.
    input wire [7:0] s_axi_araddr,    // AXI read address.
    input wire [2:0] s_axi_arprot,    // AXI read protection, unused.
    input wire s_axi_arvalid,         // AXI read address valid.
    output reg s_axi_arready,         // AXI read address ready.
    output reg [31:0] s_axi_rdata,    // AXI read data.
    output reg [1:0] s_axi_rresp,     // AXI read response.
    output reg s_axi_rvalid,          // AXI read data valid.
    input wire s_axi_rready           // AXI read data ready.
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    // Software registers and their pulses.
    reg [31:0] ctrl_q;
    reg [7:0] load_q;
    reg [15:0] count_q;
    reg [15:0] count_d;
    reg step_cmd_q;
    reg clear_cmd_q;
    reg shift_clock_q;

    // Write halves held until both are in.
    reg aw_got_q;
    reg w_got_q;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    // Core value and its chosen controls.
    wire [7:0] data_q;
    wire pin_rise;
    wire sw_own;
    wire [1:0] pin_mode;
    wire [1:0] sw_mode;
    reg [1:0] eff_mode;
    reg eff_sin_r;
    reg eff_sin_l;
    reg [7:0] eff_load;
    reg eff_step;
    wire eff_clear;
    wire drive_d;

    // Handshake strobes.
    wire wr_fire;
    wire rd_fire;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode shared by both channels. Unmapped offsets answer
    // with a slave error, so a wrong address shows up at once.

    function [1:0] resp_for;
        input [7:0] addr;
        begin
            case (addr)
                `USR_CTRL_OFS: resp_for = `USR_RESP_OKAY;
                `USR_CMD_OFS: resp_for = `USR_RESP_OKAY;
                `USR_LOAD_OFS: resp_for = `USR_RESP_OKAY;
                `USR_STAT_OFS: resp_for = `USR_RESP_OKAY;
                `USR_COUNT_OFS: resp_for = `USR_RESP_OKAY;
                default: resp_for = `USR_RESP_SLVERR;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Shift clock edge detection. Pins are synchronous to aclk, so a single
    // delay flop gives the rising edge without a synchroniser.
    // It resets low, the pin's idle level, so no false step follows reset.
    // A pin left high steps once; it must fall before the next step.

    always @(posedge aclk) begin
        if (!aresetn) begin
            shift_clock_q <= 1'b0;
        end else if (ce) begin
            shift_clock_q <= shift_clock;
        end
    end

    assign pin_rise = shift_clock & ~shift_clock_q;

    ////////////////////////////////////////////////////////////////////////////
    // Source selection. With the own bit clear the pins steer the register;
    // with it set the control, load and command registers do. The master
    // clear pin acts in either case so the board can always force zero.
    // Software mode lets a program drive the register with no pin toggling.

    assign sw_own = ctrl_q[`USR_CTRL_OWN];
    assign pin_mode = {mode_select_high, mode_select_low};
    assign sw_mode = {ctrl_q[`USR_CTRL_MODE_HI], ctrl_q[`USR_CTRL_MODE_LO]};

    always @* begin
        if (sw_own) begin
            eff_mode = sw_mode;
            eff_sin_r = ctrl_q[`USR_CTRL_SIN_R];
            eff_sin_l = ctrl_q[`USR_CTRL_SIN_L];
            eff_load = load_q;
            eff_step = step_cmd_q;
        end else begin
            eff_mode = pin_mode;
            eff_sin_r = serial_in_right;
            eff_sin_l = serial_in_left;
            eff_load = parallel_bus_i;
            eff_step = pin_rise;
        end
    end

    // Clear does not wait for a shift clock edge; it lands on the next aclk
    // edge, which is the quickest any flop-based output can respond.
    assign eff_clear = ~master_clear_n | clear_cmd_q;

    // The core holds the bits; this level picks its action each edge.
    usr_core u_core (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .clear(eff_clear),
        .step(eff_step),
        .mode(eff_mode),
        .sin_right(eff_sin_r),
        .sin_left(eff_sin_l),
        .load_data(eff_load),
        .data_q(data_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin outputs. The taps are the core flops themselves.
    // The taps ignore the enables, so a chain shifts with its bus released.
    // Enables gate only the bus.

    assign serial_tap_first = data_q[0];
    assign serial_tap_last = data_q[7];
    assign parallel_bus_o = data_q;

    // The bus is released whenever the effective mode selects a load, so the loading
    // device never fights the source it is sampling. The enable is registered,
    // so it follows the pins one aclk cycle late. A source that selects load
    // and raises shift_clock in one cycle may still find the bus driven.
    // Such a source loads the device's own value in that step.
    assign drive_d = ~out_enable_a_n & ~out_enable_b_n
                     & (eff_mode != `USR_MODE_LOAD);

    always @(posedge aclk) begin
        if (!aresetn) begin
            parallel_bus_oe_n <= 1'b1;
        end else if (ce) begin
            parallel_bus_oe_n <= ~drive_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operation counter: counts steps taken in a shifting or loading mode.
    // It wraps at 16 bits, so software works with differences.
    // Hold steps are not counted.

    always @* begin
        count_d = count_q;
        if (eff_step && !eff_clear && eff_mode != `USR_MODE_HOLD) begin
            count_d = count_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel. Address and data are taken in either order,
    // one write at a time; the response follows once both are held.

    assign wr_fire = aw_got_q & w_got_q & ~s_axi_bvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `USR_RESP_OKAY;
        end else if (ce) begin
            // Each ready drops after its handshake and stays low until the
            // response is taken, so a held word is never overwritten.
            s_axi_awready <= ~aw_got_q & ~(s_axi_awvalid & s_axi_awready)
                             & ~s_axi_bvalid;
            s_axi_wready <= ~w_got_q & ~(s_axi_wvalid & s_axi_wready)
                            & ~s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // A status write is answered OKAY and ignored.
                s_axi_bresp <= resp_for(aw_addr_q);
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes. Command bits are one-cycle pulses that go to the core
    // in the cycle after the write. Only byte lane 0 carries control bits.
    // A write with lane 0 off is answered but changes nothing.

    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= `USR_CTRL_RST;
            load_q <= `USR_DATA_RST;
            count_q <= `USR_COUNT_RST;
            step_cmd_q <= 1'b0;
            clear_cmd_q <= 1'b0;
        end else if (ce) begin
            step_cmd_q <= 1'b0;
            clear_cmd_q <= 1'b0;
            count_q <= count_d;
            if (wr_fire && w_strb_q[0]) begin
                case (aw_addr_q)
                    `USR_CTRL_OFS: ctrl_q <= {27'h0, w_data_q[4:0]};
                    `USR_CMD_OFS: begin
                        // With both pulses set, the clear wins in the core.
                        step_cmd_q <= w_data_q[`USR_CMD_STEP];
                        clear_cmd_q <= w_data_q[`USR_CMD_CLEAR];
                    end
                    `USR_LOAD_OFS: load_q <= w_data_q[7:0];
                    // A write clears the counter; a step in the same cycle
                    // is lost, which software accepts by writing it.
                    `USR_COUNT_OFS: count_q <= `USR_COUNT_RST;
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel. Data is captured at the address handshake, so
    // rvalid rises at the edge after arvalid meets arready.
    // A step in the capture cycle shows only on the next read.

    assign rd_fire = s_axi_arvalid & s_axi_arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `USR_RESP_OKAY;
        end else if (ce) begin
            // One read at a time: arready waits until the data is taken.
            s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= resp_for(s_axi_araddr);
                case (s_axi_araddr)
                    `USR_CTRL_OFS: s_axi_rdata <= ctrl_q;
                    `USR_CMD_OFS: s_axi_rdata <= 32'h0000_0000;
                    `USR_LOAD_OFS: s_axi_rdata <= {24'h0, load_q};
                    `USR_STAT_OFS: begin
                        // Mode and drive show the effective source.
                        s_axi_rdata <= {21'h0,
                                        eff_mode,
                                        ~parallel_bus_oe_n,
                                        data_q};
                    end
                    `USR_COUNT_OFS: s_axi_rdata <= {16'h0, count_q};
                    default: s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* verification/test_universal_shift_register.sv */
/* Self-checking bench for usr_top: pin steps in all modes, clear, enables, AXI.
 * Assumes the partner model resolves the bus and the checker is bound. */
`timescale 1ns/1ps
module test_universal_shift_register;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg shift_clock = 1'b0;
    reg master_clear_n = 1'b1;
    reg mode_select_low = 1'b0;
    reg mode_select_high = 1'b0;
    reg serial_in_right = 1'b0;
    reg serial_in_left = 1'b0;
    reg out_enable_a_n = 1'b1;
    reg out_enable_b_n = 1'b1;
    reg drive_en = 1'b0;
    reg [7:0] drive_val = 8'h00;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg [7:0] s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire [7:0] parallel_bus_i, parallel_bus_o;
    wire parallel_bus_oe_n, serial_tap_first, serial_tap_last;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer seed = 65349;
    integer fail_count = 0;
    integer check_count = 0;
    integer i;
    reg [7:0] exp_q;
    reg [31:0] r;
    always #10 aclk = ~aclk;
    usr_top i_dut (.aclk, .aresetn, .ce(1'b1), .shift_clock, .master_clear_n, .mode_select_low,
        .mode_select_high, .serial_in_right, .serial_in_left, .out_enable_a_n, .out_enable_b_n,
        .parallel_bus_i, .parallel_bus_o, .parallel_bus_oe_n, .serial_tap_first,
        .serial_tap_last, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    usr_bus_partner i_partner (.aclk, .drive_en, .drive_val, .parallel_bus_oe_n,
        .parallel_bus_o, .wire_level(parallel_bus_i));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            if (fail_count == 0 && check_count > 0) begin
                $display("ALL CHECKS OK");
            end else begin
                $display("CHECKS NOT OK");
            end
            $finish;
        end
    endtask
    task chk_pin(input [7:0] got, input [7:0] want);
        begin
            check_count = check_count + 1;
            if (got !== want) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t pins %h want %h", $time, got, want);
            end
        end
    endtask
    task chk_axi(input [33:0] got, input [33:0] want);
        begin
            check_count = check_count + 1;
            if (got !== want) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t bus %h want %h", $time, got, want);
            end
        end
    endtask
    function [7:0] nxt(input [1:0] md, input [7:0] d, input sr, input sl, input [7:0] v);
        begin
            case (md)
                2'b01: nxt = {d[6:0], sr};
                2'b10: nxt = {sl, d[7:1]};
                2'b11: nxt = v;
                default: nxt = d;
            endcase
        end
    endfunction
    // One transfer; readies are raised only after valid so the slave must hold.
    task axi_xfer(input wr, input [7:0] a, input [31:0] d, input [1:0] resp);
        integer n;
        reg done;
        reg [33:0] got;
        begin
            done = 1'b0;
            got = 34'h0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= wr;
            s_axi_wvalid <= wr;
            s_axi_arvalid <= !wr;
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(posedge aclk);
                done = (s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready);
                got = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
                if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
            end
            if (!done) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t bus timeout", $time);
                stop_test;
            end else begin
                chk_axi(got, {resp, wr ? 32'h0 : d});
            end
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
        end
    endtask
    task do_step(input [1:0] md, input sr, input sl, input [7:0] v, input clr);
        begin
            r = $random(seed);
            @(posedge aclk);
            {mode_select_high, mode_select_low} <= md;
            serial_in_right <= sr;
            serial_in_left <= sl;
            drive_val <= v;
            drive_en <= (md == 2'b11);
            master_clear_n <= !clr;
            out_enable_a_n <= r[0] & r[1];
            out_enable_b_n <= r[2] & r[3];
            @(posedge aclk);
            shift_clock <= 1'b1;
            @(posedge aclk);
            shift_clock <= 1'b0;
            master_clear_n <= 1'b1;
            exp_q = clr ? 8'h00 : nxt(md, exp_q, sr, sl, v);
            #1;
            chk_pin(parallel_bus_o, exp_q);
            chk_pin({serial_tap_last, 6'h0, serial_tap_first}, exp_q & 8'h81);
            chk_pin({7'h0, parallel_bus_oe_n},
                {7'h0, out_enable_a_n | out_enable_b_n | (md == 2'b11)});
            if (parallel_bus_oe_n === 1'b0) chk_pin(parallel_bus_i, exp_q);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        exp_q = 8'h00;
        axi_xfer(1'b0, 8'h00, 32'h0, 2'b00);
        axi_xfer(1'b0, 8'h0c, 32'h0, 2'b00);
        axi_xfer(1'b1, 8'h00, 32'h18, 2'b00);
        axi_xfer(1'b0, 8'h00, 32'h18, 2'b00);
        axi_xfer(1'b1, 8'h00, 32'h0, 2'b00);
        axi_xfer(1'b1, 8'h20, 32'h5a, 2'b10);
        axi_xfer(1'b0, 8'h20, 32'h0, 2'b10);
        axi_xfer(1'b0, 8'h04, 32'h0, 2'b00);
        axi_xfer(1'b1, 8'h10, 32'h0, 2'b00);
        do_step(2'b11, 1'b0, 1'b0, 8'ha5, 1'b0);
        do_step(2'b00, 1'b1, 1'b1, 8'h3c, 1'b0);
        do_step(2'b01, 1'b1, 1'b0, 8'h00, 1'b0);
        do_step(2'b10, 1'b0, 1'b1, 8'h00, 1'b0);
        axi_xfer(1'b0, 8'h10, 32'h3, 2'b00);
        axi_xfer(1'b0, 8'h0c, {21'h0, 2'b10, ~(out_enable_a_n | out_enable_b_n), exp_q}, 2'b00);
        out_enable_a_n <= 1'b1;
        axi_xfer(1'b1, 8'h08, 32'h3c, 2'b00);
        axi_xfer(1'b0, 8'h08, 32'h3c, 2'b00);
        axi_xfer(1'b1, 8'h00, 32'h7, 2'b00);
        axi_xfer(1'b1, 8'h04, 32'h1, 2'b00);
        axi_xfer(1'b0, 8'h0c, {21'h0, 2'b11, 1'b0, 8'h3c}, 2'b00);
        axi_xfer(1'b1, 8'h04, 32'h2, 2'b00);
        chk_pin(parallel_bus_o, 8'h00);
        axi_xfer(1'b1, 8'h00, 32'h0, 2'b00);
        do_step(2'b01, 1'b1, 1'b1, 8'h00, 1'b1);
        do_step(2'b11, 1'b0, 1'b0, 8'h96, 1'b0);
        for (i = 0; i < 8; i = i + 1) begin
            do_step(2'b01, serial_tap_last, 1'b0, 8'h00, 1'b0);
        end
        chk_pin(parallel_bus_o, 8'h96);
        for (i = 0; i < 60; i = i + 1) begin
            r = $random(seed);
            do_step(r[1:0], r[2], r[3], r[11:4], r[14:12] == 3'h0);
        end
        stop_test;
    end
endmodule

/* verification/usr_bus_partner.sv */
/* Far-side partner on the shared parallel bus: resolves the wire level.
 * Assumes the bench says when and what to drive; the device enable gates it. */
`timescale 1ns/1ps
module usr_bus_partner (
    input wire aclk, // Clock.
    input wire drive_en, // Partner wants the bus.
    input wire [7:0] drive_val, // Value to drive.
    input wire parallel_bus_oe_n, // Device enable, low drives.
    input wire [7:0] parallel_bus_o, // Device value.
    output wire [7:0] wire_level // Level on the pins.
);
    reg [7:0] last_q = 8'h00;
    // An undriven bus has no pull, so it toggles rather than keep a stale value.
    assign wire_level = !parallel_bus_oe_n ? parallel_bus_o :
        (drive_en ? drive_val : ~last_q);
    always @(posedge aclk) begin
        last_q <= wire_level;
    end
endmodule

/* verification/usr_monitor.sv */
/* Checker on the usr_top pins: shifts, load, clear, bus enables, taps, AXI holds.
 * Assumes ce stays high and software steps land only while bvalid is high. */
`timescale 1ns/1ps
module usr_monitor (
    input wire aclk, // Clock.
    input wire aresetn, // Reset, active low.
    input wire ce, // Clock enable.
    input wire shift_clock, // Shift clock pin.
    input wire master_clear_n, // Clear pin.
    input wire mode_select_low, // Select, low bit.
    input wire mode_select_high, // Select, high bit.
    input wire serial_in_right, // Right serial input.
    input wire serial_in_left, // Left serial input.
    input wire out_enable_a_n, // Enable a.
    input wire out_enable_b_n, // Enable b.
    input wire [7:0] parallel_bus_i, // Pin level.
    input wire [7:0] parallel_bus_o, // Stored value.
    input wire parallel_bus_oe_n, // Bus enable, low drives.
    input wire serial_tap_first, // Bit 0.
    input wire serial_tap_last, // Bit 7.
    input wire [1:0] s_axi_bresp, // Write response.
    input wire s_axi_bvalid, // Write response valid.
    input wire s_axi_bready, // Write response ready.
    input wire [31:0] s_axi_rdata, // Read data.
    input wire s_axi_rvalid, // Read valid.
    input wire s_axi_rready // Read ready.
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire [1:0] md = {mode_select_high, mode_select_low};
    sequence s_rise;
        !shift_clock && ce ##1 shift_clock && ce && master_clear_n;
    endsequence
    property p_right;
        s_rise ##0 md == 2'b01 |=>
            parallel_bus_o == {$past(parallel_bus_o[6:0]), $past(serial_in_right)};
    endproperty
    property p_left;
        s_rise ##0 md == 2'b10 |=>
            parallel_bus_o == {$past(serial_in_left), $past(parallel_bus_o[7:1])};
    endproperty
    property p_load;
        s_rise ##0 md == 2'b11 |=> parallel_bus_o == $past(parallel_bus_i);
    endproperty
    property p_hold;
        ce && master_clear_n && md == 2'b00 |=> $stable(parallel_bus_o);
    endproperty
    property p_edge;
        ce && master_clear_n && !s_axi_bvalid && !(shift_clock && !$past(shift_clock))
            |=> $stable(parallel_bus_o);
    endproperty
    property p_clear;
        ce && !master_clear_n |-> ##1 parallel_bus_o == 8'h00;
    endproperty
    property p_oe;
        ce |=> parallel_bus_oe_n ==
            ($past(out_enable_a_n) || $past(out_enable_b_n) || $past(md) == 2'b11);
    endproperty
    property p_release;
        ce && md == 2'b11 |=> parallel_bus_oe_n;
    endproperty
    property p_taps;
        serial_tap_first == parallel_bus_o[0] && serial_tap_last == parallel_bus_o[7];
    endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_right: assert property (p_right) else $error("right shift wrong");
    a_left: assert property (p_left) else $error("left shift wrong");
    a_load: assert property (p_load) else $error("load wrong");
    a_hold: assert property (p_hold) else $error("hold changed data");
    a_edge: assert property (p_edge) else $error("change without edge");
    a_clear: assert property (p_clear) else $error("clear failed");
    a_oe: assert property (p_oe) else $error("bus enable wrong");
    a_release: assert property (p_release) else $error("bus driven in load");
    a_taps: assert property (p_taps) else $error("taps wrong");
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind usr_top usr_monitor i_mon (.aclk, .aresetn, .ce, .shift_clock, .master_clear_n,
    .mode_select_low, .mode_select_high, .serial_in_right, .serial_in_left, .out_enable_a_n,
    .out_enable_b_n, .parallel_bus_i, .parallel_bus_o, .parallel_bus_oe_n, .serial_tap_first,
    .serial_tap_last, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);
